/* hdl/seek_exerciser_defs.vh */
// Purpose: Shared constants for the seek exerciser and error logger.
// Assumes: 125 MHz clock; cylinder numbers are 10 bits wide.
// Notes:   Register offsets are word indices on the plain register port.
`ifndef SEEK_EXERCISER_DEFS_VH
`define SEEK_EXERCISER_DEFS_VH

`define CLK_PERIOD_NS   8
`define PAUSE_UNIT_NS   1000000
`define MAX_CYLINDER    10'h2E8

`define REG_FUNC        4'h0
`define REG_SEEK_CODE   4'h1
`define REG_PARAM1      4'h2
`define REG_PARAM2      4'h3
`define REG_PARAM3      4'h4
`define REG_STATUS      4'h5
`define REG_DISPLAY     4'h6
`define REG_TARGET      4'h7

`define FUNC_ONLINE     8'hA0
`define FUNC_ONLINE_LOG 8'hA1
`define FUNC_SEEK       8'hB0
`define FUNC_SEEK_LOG   8'hB1
`define FUNC_LOG_OUT    8'hC0

`define PAT_INC         4'h3
`define PAT_DEC         4'h4
`define PAT_XN_INC      4'h5
`define PAT_XN_DEC      4'h6
`define PAT_RANDOM      4'h7
`define PAT_HOME_ALT    4'h8

`define ERR_SEEK_CMD    8'h11
`define ERR_RW_CMD      8'h12
`define ERR_PROTECT     8'h15
`define ERR_HOME_TMO    8'h21
`define ERR_SEEK_TMO    8'h22
`define ERR_GB_SEEK     8'h24
`define ERR_GB_LINEAR   8'h25
`define ERR_ILLEGAL_CYL 8'h27

`define DISP_TOTAL      8'h0F
`define DISP_NONE       8'h00
`define DISP_CLEAR      8'h0C

`define LAMP_POWERUP    2'h0
`define LAMP_FAULT      2'h1
`define LAMP_SEEK_ERR   2'h2
`define LAMP_READY      2'h3

`define LFSR_SEED       16'hACE1

`endif

/* hdl/seek_target_gen.v */
// Purpose: Produces the cylinder sequence of the range and home seek patterns.
// Assumes: Lower limit is below upper limit when a range pattern is loaded.
// Notes:   load gives the first target, each step gives the next one.
`timescale 1ns/100ps
`include "seek_exerciser_defs.vh"
module seek_target_gen #(
	parameter CW = 10
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          ce,
	input  wire          load,
	input  wire          step,
	input  wire [3:0]    pattern,
	input  wire [CW-1:0] lower,
	input  wire [CW-1:0] upper,
	input  wire [CW-1:0] target_cylinder_first,
	output reg  [CW-1:0] target_q,
	output reg           home_q
);
	reg [CW-1:0] peak_q;
	reg          at_base_q;
	reg [15:0]   lfsr_q;
	wire [CW-1:0] span = upper - lower;

	// Folds a raw draw into 0..span so every random target is in range.
	function [CW-1:0] fold;
		input [CW-1:0] v;
		input [CW-1:0] s;
		reg   [CW-1:0] m;
		reg   [CW-1:0] r;
		integer        i;
		begin
			m = s;
			for (i = 1; i < CW; i = i * 2)
				m = m | (m >> i);
			r = v & m;
			if (r > s)
				r = r - s - 1'b1;
			fold = r;
		end
	endfunction

	wire [CW-1:0] rnd = lower + fold(lfsr_q[CW-1:0], span);

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			target_q  <= {CW{1'b0}};
			peak_q    <= {CW{1'b0}};
			at_base_q <= 1'b1;
			home_q    <= 1'b0;
			lfsr_q    <= `LFSR_SEED;
		end
		else if (ce)
		begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			if (load)
			begin
				at_base_q <= 1'b1;
				home_q    <= 1'b0;
				case (pattern)
					`PAT_DEC, `PAT_XN_DEC:
					begin
						target_q <= upper;
						peak_q   <= upper;
					end
					`PAT_RANDOM:
						target_q <= rnd;
					`PAT_HOME_ALT:
					begin
						target_q <= target_cylinder_first;
						home_q   <= (target_cylinder_first == {CW{1'b0}});
					end
					default:
					begin
						target_q <= lower;
						peak_q   <= lower;
					end
				endcase
			end
			else if (step)
			begin
				case (pattern)
					`PAT_INC:
						target_q <= (target_q >= upper) ? lower : target_q + 1'b1;
					`PAT_DEC:
						target_q <= (target_q <= lower) ? upper : target_q - 1'b1;
					`PAT_XN_INC:
					begin
						at_base_q <= ~at_base_q;
						if (at_base_q)
						begin
							peak_q   <= (peak_q >= upper) ? lower + 1'b1 : peak_q + 1'b1;
							target_q <= (peak_q >= upper) ? lower + 1'b1 : peak_q + 1'b1;
						end
						else
							target_q <= lower;
					end
					`PAT_XN_DEC:
					begin
						at_base_q <= ~at_base_q;
						if (at_base_q)
						begin
							peak_q   <= (peak_q <= lower) ? upper - 1'b1 : peak_q - 1'b1;
							target_q <= (peak_q <= lower) ? upper - 1'b1 : peak_q - 1'b1;
						end
						else
							target_q <= upper;
					end
					`PAT_RANDOM:
						target_q <= rnd;
					`PAT_HOME_ALT:
						home_q <= (target_cylinder_first == {CW{1'b0}}) ? 1'b1 : ~home_q;
					default:
						target_q <= target_q;
				endcase
			end
		end
	end
endmodule

/* hdl/error_log.v */
// Purpose: Counts logged error codes and steps through them for display.
// Assumes: Codes 1x and 2x are loggable; others are ignored.
// Notes:   An event in the clearing cycle is still counted.
`timescale 1ns/100ps
`include "seek_exerciser_defs.vh"
module error_log (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       log_event,
	input  wire [7:0] log_code,
	input  wire       clear,
	input  wire       show_first,
	input  wire       advance,
	output reg  [7:0] disp_code_q,
	output reg  [7:0] disp_count_q
);
	reg [7:0] cnt [0:31];
	reg [7:0] total_q;
	reg [4:0] ptr_q;
	reg       scan_q;
	reg       on_total_q;
	integer   i;

	wire       loggable = (log_code[7:6] == 2'h0) && (log_code[5] ^ log_code[4]);
	wire [4:0] idx = {log_code[5], log_code[3:0]};

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < 32; i = i + 1)
				cnt[i] <= 8'h00;
			total_q      <= 8'h00;
			ptr_q        <= 5'h00;
			scan_q       <= 1'b0;
			on_total_q   <= 1'b1;
			disp_code_q  <= `DISP_NONE;
			disp_count_q <= 8'h00;
		end
		else if (ce)
		begin
			if (clear)
			begin
				for (i = 0; i < 32; i = i + 1)
					cnt[i] <= 8'h00;
				total_q      <= 8'h00;
				on_total_q   <= 1'b1;
				scan_q       <= 1'b0;
				disp_code_q  <= `DISP_TOTAL;
				disp_count_q <= 8'h00;
			end
			else if (show_first || (advance && on_total_q == 1'b0 && ptr_q == 5'h1F))
			begin
				on_total_q   <= 1'b1;
				scan_q       <= 1'b0;
				disp_code_q  <= (total_q == 8'h00) ? `DISP_NONE : `DISP_TOTAL;
				disp_count_q <= total_q;
			end
			else if (advance)
			begin
				scan_q     <= 1'b1;
				on_total_q <= 1'b0;
				ptr_q      <= on_total_q ? 5'h00 : ptr_q + 5'h01;
			end
			else if (scan_q)
			begin
				if (cnt[ptr_q] != 8'h00)
				begin
					scan_q       <= 1'b0;
					disp_code_q  <= {2'h0, ptr_q[4], ~ptr_q[4], ptr_q[3:0]};
					disp_count_q <= cnt[ptr_q];
				end
				else if (ptr_q == 5'h1F)
				begin
					scan_q       <= 1'b0;
					on_total_q   <= 1'b1;
					disp_code_q  <= (total_q == 8'h00) ? `DISP_NONE : `DISP_TOTAL;
					disp_count_q <= total_q;
				end
				else
					ptr_q <= ptr_q + 5'h01;
			end
			if (log_event && loggable)
			begin
				if (cnt[idx] != 8'hFF || clear)
					cnt[idx] <= clear ? 8'h01 : cnt[idx] + 8'h01;
				if (total_q != 8'hFF || clear)
					total_q <= clear ? 8'h01 : total_q + 8'h01;
			end
		end
	end
endmodule

/* hdl/seek_exerciser_error_logger.v */
// Purpose: Diagnostic seek exerciser, error logger, write lock and status lamps.
// Assumes: Keypad and lock switch are asynchronous pins; drive signals share clk.
// Notes:   Software sets function code, seek code and parameters over the port.
`timescale 1ns/100ps
`include "seek_exerciser_defs.vh"
module seek_exerciser_error_logger #(
	parameter CW         = 10,
	parameter CYC_PER_MS = `PAUSE_UNIT_NS / `CLK_PERIOD_NS
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          ce,
	input  wire [3:0]    reg_addr,
	input  wire [15:0]   reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [15:0]   reg_rdata_q,
	input  wire          start_stop_key,
	input  wire          log_reset_key,
	input  wire          function_select_key,
	input  wire          load_key,
	input  wire          write_lock_key,
	input  wire [3:0]    digit_key,
	input  wire          digit_pressed,
	input  wire          lock_switch,
	input  wire          drive_busy,
	input  wire          drive_ready,
	input  wire          drive_on_cylinder,
	input  wire          cmd_seek,
	input  wire          cmd_offset,
	input  wire          cmd_home,
	input  wire          cmd_read,
	input  wire          cmd_write,
	input  wire [CW-1:0] cmd_cylinder,
	input  wire          seek_done,
	input  wire          home_timeout,
	input  wire          seek_timeout,
	input  wire          guard_band_seek,
	input  wire          guard_band_linear,
	input  wire          fault_clear,
	output wire          offline,
	output wire          write_refused,
	output reg           seek_strobe_q,
	output reg           home_strobe_q,
	output reg  [CW-1:0] seek_cylinder_q,
	output reg  [6:0]    unit_status_lamps_q,
	output reg  [7:0]    error_code_q,
	output reg  [7:0]    display_code_q,
	output reg  [7:0]    display_value_q
);
	localparam M_IDLE    = 2'd0;
	localparam M_LOG     = 2'd1;
	localparam M_LOG_ARM = 2'd2;
	localparam M_SEEK    = 2'd3;

	localparam S_IDLE  = 2'd0;
	localparam S_ISSUE = 2'd1;
	localparam S_WAIT  = 2'd2;
	localparam S_PAUSE = 2'd3;

	localparam PW = 11;

	// Pins pass three flops; a level is taken once the last two agree.
	reg [PW-1:0] sync1_q;
	reg [PW-1:0] sync2_q;
	reg [PW-1:0] sync3_q;
	reg [PW-1:0] pin_q;
	reg [PW-1:0] pin_prev_q;
	wire [PW-1:0] pins = {lock_switch, digit_pressed, digit_key, write_lock_key,
		load_key, function_select_key, log_reset_key, start_stop_key};

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q    <= {PW{1'b0}};
			sync2_q    <= {PW{1'b0}};
			sync3_q    <= {PW{1'b0}};
			pin_q      <= {PW{1'b0}};
			pin_prev_q <= {PW{1'b0}};
		end
		else if (ce)
		begin
			sync1_q    <= pins;
			sync2_q    <= sync1_q;
			sync3_q    <= sync2_q;
			pin_q      <= (pin_q & (sync2_q ^ sync3_q)) | (sync2_q & sync3_q);
			pin_prev_q <= pin_q;
		end
	end

	wire [PW-1:0] press = pin_q & ~pin_prev_q;
	wire key_st   = press[0];
	wire key_rt   = press[1];
	wire key_fm   = press[2];
	wire key_ld   = press[3];
	wire lock_sw  = pin_q[10];
	wire combo    = pin_q[4] & pin_q[9] & (press[4] | press[9]);
	wire [3:0] digit = pin_q[8:5];

	reg [7:0]    func_q;
	reg [7:0]    seek_code_q;
	reg [CW-1:0] param1_q;
	reg [CW-1:0] param2_q;
	reg [7:0]    param3_q;
	reg [1:0]    mode_q;
	reg [1:0]    sstate_q;
	reg          lock_key_q;
	reg          seek_err_q;
	reg          fault_q;
	reg [16:0]   ms_cnt_q;
	reg [7:0]    ms_left_q;

	wire         lock_active = lock_key_q | lock_sw;
	wire [3:0]   pattern = seek_code_q[7:4];
	wire         repeat_run = seek_code_q[0];
	wire         log_en = (func_q == `FUNC_ONLINE_LOG) || (func_q == `FUNC_SEEK_LOG);
	wire         seek_func = (func_q == `FUNC_SEEK) || (func_q == `FUNC_SEEK_LOG);
	wire [CW-1:0] gen_target;
	wire         gen_home;
	reg          gen_load;
	reg          gen_step;

	assign offline = (mode_q != M_IDLE);
	assign write_refused = cmd_write & lock_active;

	// Register port: one cycle write, read data stands the cycle after.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			func_q      <= `FUNC_ONLINE;
			seek_code_q <= 8'h00;
			param1_q    <= {CW{1'b0}};
			param2_q    <= {CW{1'b0}};
			param3_q    <= 8'h00;
			reg_rdata_q <= 16'h0000;
		end
		else if (ce)
		begin
			if (reg_wr)
			begin
				if (reg_addr == `REG_FUNC)
					func_q <= reg_wdata[7:0];
				else if (reg_addr == `REG_SEEK_CODE)
					seek_code_q <= reg_wdata[7:0];
				else if (reg_addr == `REG_PARAM1)
					param1_q <= reg_wdata[CW-1:0];
				else if (reg_addr == `REG_PARAM2)
					param2_q <= reg_wdata[CW-1:0];
				else if (reg_addr == `REG_PARAM3)
					param3_q <= reg_wdata[7:0];
			end
			if (!reg_rd)
				reg_rdata_q <= 16'h0000;
			else if (reg_addr == `REG_FUNC)
				reg_rdata_q <= {8'h00, func_q};
			else if (reg_addr == `REG_SEEK_CODE)
				reg_rdata_q <= {8'h00, seek_code_q};
			else if (reg_addr == `REG_PARAM1)
				reg_rdata_q <= {{(16-CW){1'b0}}, param1_q};
			else if (reg_addr == `REG_PARAM2)
				reg_rdata_q <= {{(16-CW){1'b0}}, param2_q};
			else if (reg_addr == `REG_PARAM3)
				reg_rdata_q <= {8'h00, param3_q};
			else if (reg_addr == `REG_STATUS)
				reg_rdata_q <= {2'h0, mode_q, sstate_q, lock_sw, lock_key_q,
					error_code_q};
			else if (reg_addr == `REG_DISPLAY)
				reg_rdata_q <= {display_code_q, display_value_q};
			else if (reg_addr == `REG_TARGET)
				reg_rdata_q <= {{(16-CW){1'b0}}, seek_cylinder_q};
			else
				reg_rdata_q <= 16'h0000;
		end
	end

	// Write lock from the keypad; the internal switch overrides it.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lock_key_q <= 1'b0;
		else if (ce && combo)
		begin
			if (digit == 4'h1)
				lock_key_q <= 1'b1;
			else if (digit == 4'h0 && !lock_sw)
				lock_key_q <= 1'b0;
		end
	end

	// Panel mode machine.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mode_q <= M_IDLE;
		else if (ce)
		begin
			case (mode_q)
				M_IDLE:
					if (key_st && func_q == `FUNC_LOG_OUT)
						mode_q <= M_LOG;
					else if (key_st && seek_func)
						mode_q <= M_SEEK;
				M_LOG:
					if (key_fm)
						mode_q <= M_IDLE;
					else if (key_rt)
						mode_q <= M_LOG_ARM;
				M_LOG_ARM:
					if (key_ld)
						mode_q <= M_LOG;
					else if (key_st || key_fm)
						mode_q <= M_IDLE;
				default:
					if (key_fm || (sstate_q == S_IDLE && !gen_load && !key_st))
						mode_q <= M_IDLE;
			endcase
		end
	end

	wire log_first = (mode_q == M_IDLE) && key_st && (func_q == `FUNC_LOG_OUT);
	wire log_next  = (mode_q == M_LOG) && key_st;
	wire log_clear = (mode_q == M_LOG_ARM) && key_ld;
	wire [7:0] log_code;
	wire [7:0] log_count;

	// Seek engine: issue, wait for completion, step the pattern, pause.
	always @*
	begin
		gen_load = (mode_q == M_IDLE) && key_st && seek_func;
		gen_step = (sstate_q == S_WAIT) && seek_done;
	end

	wire pause_over = (ms_left_q == 8'h00);
	// A function press, or a stop press in a repeat run, is honoured in every busy state so that none is lost.
	wire halt = key_fm || (repeat_run && key_st);

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sstate_q        <= S_IDLE;
			seek_strobe_q   <= 1'b0;
			home_strobe_q   <= 1'b0;
			seek_cylinder_q <= {CW{1'b0}};
			ms_cnt_q        <= 17'h00000;
			ms_left_q       <= 8'h00;
		end
		else if (ce)
		begin
			seek_strobe_q <= 1'b0;
			home_strobe_q <= 1'b0;
			case (sstate_q)
				S_IDLE:
					if (gen_load)
						sstate_q <= S_ISSUE;
				S_ISSUE:
					if (halt)
						sstate_q <= S_IDLE;
					else
					begin
						if (gen_home)
							home_strobe_q <= 1'b1;
						else
							seek_strobe_q <= 1'b1;
						seek_cylinder_q <= gen_home ? {CW{1'b0}} : gen_target;
						sstate_q        <= S_WAIT;
					end
				S_WAIT:
					if (halt)
						sstate_q <= S_IDLE;
					else if (seek_done)
					begin
						ms_left_q <= param3_q;
						ms_cnt_q  <= 17'h00000;
						if (repeat_run || (pattern == `PAT_HOME_ALT && !gen_home &&
							seek_cylinder_q != {CW{1'b0}}))
							sstate_q <= S_PAUSE;
						else
							sstate_q <= S_IDLE;
					end
				default:
					if (halt)
						sstate_q <= S_IDLE;
					else if (pause_over)
						sstate_q <= S_ISSUE;
					else if (ms_cnt_q == CYC_PER_MS[16:0] - 17'h00001)
					begin
						ms_cnt_q  <= 17'h00000;
						ms_left_q <= ms_left_q - 8'h01;
					end
					else
						ms_cnt_q <= ms_cnt_q + 17'h00001;
			endcase
		end
	end

	// Fault and seek error detection, one code per cycle by priority.
	reg [7:0] err_d;
	always @*
	begin
		err_d = 8'h00;
		if (cmd_seek && cmd_cylinder > `MAX_CYLINDER)
			err_d = `ERR_ILLEGAL_CYL;
		else if (home_timeout)
			err_d = `ERR_HOME_TMO;
		else if (seek_timeout)
			err_d = `ERR_SEEK_TMO;
		else if (guard_band_seek)
			err_d = `ERR_GB_SEEK;
		else if (guard_band_linear)
			err_d = `ERR_GB_LINEAR;
		else if (write_refused)
			err_d = `ERR_PROTECT;
		else if (((cmd_seek || cmd_offset) && (drive_busy || seek_err_q)) ||
			(cmd_home && drive_busy))
			err_d = `ERR_SEEK_CMD;
		else if ((cmd_read || cmd_write) &&
			(!drive_ready || !drive_on_cylinder || seek_err_q))
			err_d = `ERR_RW_CMD;
	end

	wire new_err = (err_d != 8'h00);
	// In logging seek test the error is cancelled right after it is logged.
	wire auto_clr = (func_q == `FUNC_SEEK_LOG) && (error_code_q != 8'h00);

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			error_code_q <= 8'h00;
			seek_err_q   <= 1'b0;
			fault_q      <= 1'b0;
		end
		else if (ce)
		begin
			if (new_err)
			begin
				error_code_q <= err_d;
				seek_err_q   <= err_d[5];
				fault_q      <= err_d[4];
			end
			else if (fault_clear || auto_clr)
			begin
				error_code_q <= 8'h00;
				seek_err_q   <= 1'b0;
				fault_q      <= 1'b0;
			end
		end
	end

	// Lamps: class in the top two, condition in the low three.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			unit_status_lamps_q <= 7'h00;
		else if (ce)
		begin
			if (seek_err_q)
				unit_status_lamps_q <= {`LAMP_SEEK_ERR, 2'h0, error_code_q[2:0]};
			else if (fault_q)
				unit_status_lamps_q <= {`LAMP_FAULT, 2'h0, error_code_q[2:0]};
			else if (drive_ready)
				unit_status_lamps_q <= {`LAMP_READY, 3'h0, lock_active, 1'b0};
			else
				unit_status_lamps_q <= {`LAMP_POWERUP, 5'h00};
		end
	end

	// Display mux.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			display_code_q  <= 8'h00;
			display_value_q <= 8'h00;
		end
		else if (ce)
		begin
			if (mode_q == M_LOG_ARM)
			begin
				display_code_q  <= `DISP_CLEAR;
				display_value_q <= 8'h00;
			end
			else if (mode_q == M_LOG)
			begin
				display_code_q  <= log_code;
				display_value_q <= log_count;
			end
			else if (mode_q == M_SEEK)
			begin
				display_code_q  <= seek_code_q;
				display_value_q <= seek_cylinder_q[7:0];
			end
			else
			begin
				display_code_q  <= error_code_q;
				display_value_q <= cmd_cylinder[7:0];
			end
		end
	end

	seek_target_gen #(
		.CW       (CW)
	) u_gen (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (gen_load),
		.step     (gen_step),
		.pattern  (pattern),
		.lower    (param1_q),
		.upper    (param2_q),
		.target_cylinder_first    (param1_q),
		.target_q (gen_target),
		.home_q   (gen_home)
	);

	error_log u_log (
		.clk          (clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.log_event    (new_err && log_en),
		.log_code     (err_d),
		.clear        (log_clear),
		.show_first   (log_first),
		.advance      (log_next),
		.disp_code_q  (log_code),
		.disp_count_q (log_count)
	);
endmodule

/* testbench/seek_exerciser_error_logger_assertions.sv */
// Purpose: Port checks for the seek exerciser and error logger.
// Assumes: Timeout and protect checks start from a cleared error code.
// Notes:   Bound to the top module below.
`timescale 1ns/100ps
module seek_exerciser_checks #(
	parameter CW = 10
) (
	input wire          clk,
	input wire          rst_n,
	input wire          ce,
	input wire          reg_rd,
	input wire [15:0]   reg_rdata_q,
	input wire          lock_switch,
	input wire          cmd_seek,
	input wire          cmd_write,
	input wire [CW-1:0] cmd_cylinder,
	input wire          home_timeout,
	input wire          seek_timeout,
	input wire          guard_band_seek,
	input wire          guard_band_linear,
	input wire          write_refused,
	input wire          seek_strobe_q,
	input wire          home_strobe_q,
	input wire [CW-1:0] seek_cylinder_q,
	input wire [7:0]    error_code_q
);
	wire hit27;
	wire calm;
	assign hit27 = cmd_seek && (cmd_cylinder > 10'h2E8);
	assign calm = ce && !hit27 && (error_code_q == 8'h00);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_illegal_cyl: assert property (ce && hit27 |=> error_code_q == 8'h27)
		else $error("Illegal cylinder not reported");
	a_home_tmo: assert property (calm && home_timeout |=> error_code_q == 8'h21)
		else $error("Home timeout not reported");
	a_seek_tmo: assert property (calm && !home_timeout && seek_timeout
		|=> error_code_q == 8'h22) else $error("Seek timeout not reported");
	a_lock_switch: assert property (lock_switch [*6] ##0 cmd_write |-> write_refused)
		else $error("Switch lock did not refuse a write");
	a_refuse_cause: assert property (write_refused |-> cmd_write)
		else $error("Refusal without a write");
	a_protect_code: assert property (calm && write_refused && !guard_band_seek
		&& !guard_band_linear && !home_timeout && !seek_timeout
		|=> error_code_q == 8'h15) else $error("Refused write not reported");
	a_strobe_excl: assert property (seek_strobe_q |-> !home_strobe_q)
		else $error("Seek and home strobes together");
	a_strobe_pulse: assert property (seek_strobe_q |=> !seek_strobe_q)
		else $error("Seek strobe longer than one cycle");
	a_home_target: assert property (home_strobe_q |-> seek_cylinder_q == '0)
		else $error("Home seek with nonzero cylinder");
	a_read_idle: assert property (ce && !reg_rd |=> reg_rdata_q == 16'h0000)
		else $error("Read data outside the read cycle");
	c_seek: cover property (seek_strobe_q);
	c_home: cover property (home_strobe_q);
	c_refused: cover property (write_refused);
endmodule
bind seek_exerciser_error_logger seek_exerciser_checks #(.CW(CW)) u_seek_exerciser_checks (
	.clk, .rst_n, .ce, .reg_rd, .reg_rdata_q, .lock_switch, .cmd_seek, .cmd_write,
	.cmd_cylinder, .home_timeout, .seek_timeout, .write_refused, .seek_strobe_q,
	.home_strobe_q, .seek_cylinder_q, .error_code_q, .guard_band_seek, .guard_band_linear);

/* testbench/drive_seek_model.sv */
// Purpose: Drive seek controller that finishes each seek after a delay.
// Assumes: Seek and home strobes are one-cycle pulses.
// Notes:   Busy spans from the strobe to the done pulse.
`timescale 1ns/100ps
module drive_seek_model (
	input  wire  clk,
	input  wire  rst_n,
	input  wire  go,
	output logic seek_done,
	output logic busy,
	output wire  on_cyl
);
	logic [1:0] n_q;
	assign on_cyl = !busy;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			n_q <= 2'h0;
			seek_done <= 1'b0;
		end
		else
		begin
			seek_done <= busy && (n_q == 2'h3);
			busy <= go || (busy && (n_q != 2'h3));
			n_q <= busy ? n_q + 2'h1 : 2'h0;
		end
	end
endmodule

/* testbench/tb_seek_exerciser_error_logger.sv */
// Purpose: Self-checking bench for the seek exerciser and error logger.
// Assumes: One pause unit is 4 cycles here.
// Notes:   Keys are held long enough to pass the pin filter.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("Error %s exp %0h got %0h", n, e, a); end end
module tb_seek_exerciser_error_logger;
	logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        dp = 1'b0, sw = 1'b0, rdy = 1'b1, bsy = 1'b0, cw = 1'b0, fc = 1'b0;
	logic [3:0]  ra = 4'h0, dk = 4'h0;
	logic [15:0] wd = 16'h0000, v;
	logic [4:0]  k = 5'h00;
	logic [7:0]  ev = 8'h00;
	logic [9:0]  cc = 10'h000;
	wire  [15:0] rdq;
	wire  [9:0]  scyl;
	wire  [6:0]  lamps;
	wire  [7:0]  ec, dc, dv;
	wire         seek_done, mbusy, oncyl, offline, wref, ss, hs;
	int          bad_count = 0, checks_done = 0, cyc = 0;
	logic [7:0]  q[$];
	seek_exerciser_error_logger #(.CYC_PER_MS(4)) u_seek_exerciser_error_logger (
		.clk, .rst_n, .ce(1'b1), .reg_addr(ra), .reg_wdata(wd), .reg_wr, .reg_rd,
		.reg_rdata_q(rdq), .start_stop_key(k[0]), .log_reset_key(k[1]),
		.function_select_key(k[2]), .load_key(k[3]), .write_lock_key(k[4]),
		.digit_key(dk), .digit_pressed(dp), .lock_switch(sw), .drive_busy(mbusy | bsy),
		.drive_ready(rdy), .drive_on_cylinder(oncyl), .cmd_seek(ev[0]), .cmd_offset(ev[6]),
		.cmd_home(ev[5]), .cmd_read(ev[7]), .cmd_write(cw), .cmd_cylinder(cc), .seek_done,
		.home_timeout(ev[1]), .seek_timeout(ev[2]), .guard_band_seek(ev[3]),
		.guard_band_linear(ev[4]), .fault_clear(fc), .offline, .write_refused(wref),
		.seek_strobe_q(ss), .home_strobe_q(hs), .seek_cylinder_q(scyl),
		.unit_status_lamps_q(lamps), .error_code_q(ec), .display_code_q(dc),
		.display_value_q(dv));
	drive_seek_model u_drive_seek_model (.clk, .rst_n, .go(ss | hs), .seek_done,
		.busy(mbusy), .on_cyl(oncyl));
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (ss | hs)
			q.push_back({hs, scyl[6:0]});
		if (cyc == 30000)
		begin
			bad_count++;
			complete_run;
		end
	end
	task complete_run;
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input [3:0] x, input [15:0] d);
		@(posedge clk);
		ra <= x;
		wd <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] x);
		@(posedge clk);
		ra <= x;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = rdq;
	endtask
	task key(input [4:0] m, input [3:0] d);
		@(posedge clk);
		k <= m;
		dk <= d;
		dp <= m[4];
		repeat (8) @(posedge clk);
		k <= 5'h00;
		dp <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task wtry(input e);
		@(posedge clk);
		cw <= 1'b1;
		#1 `CHK("write refused", e, wref)
		@(posedge clk);
		cw <= 1'b0;
		fc <= 1'b1;
		#1 `CHK("protect code", e ? 8'h15 : 8'h00, ec)
		@(posedge clk);
		fc <= 1'b0;
	endtask
	task evt(input [7:0] e, input [7:0] c);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 8'h00;
		#1 `CHK("error code", c, ec)
		@(posedge clk);
		fc <= 1'b1;
		#1 if (rdy)
			`CHK("lamps", c ? {c[5] ? 2'h2 : 2'h1, 2'h0, c[2:0]} : 7'h60, lamps)
		@(posedge clk);
		fc <= 1'b0;
	endtask
	task show(input [4:0] m, input [7:0] c, input [7:0] n);
		key(m, 4'h0);
		`CHK("display code", c, dc)
		`CHK("display value", n, dv)
	endtask
	task t_seek(input [7:0] sc, input [9:0] lo, input [31:0] e);
		key(5'h04, 4'h0);
		wr(4'h0, 16'h00B0);
		wr(4'h1, {8'h00, sc});
		wr(4'h2, {6'h00, lo});
		wr(4'h3, 16'h0007);
		wr(4'h4, 16'h0001);
		q.delete();
		key(5'h01, 4'h0);
		for (int i = 0; i < 300 && q.size() < 4; i++)
			@(posedge clk);
		for (int i = 0; i < 4; i++)
			if (e)
				`CHK("target", e[31 - 8 * i -: 8], q[i])
			else
				`CHK("random in range", 1'b1, q[i] inside {[8'h05:8'h07]})
		key(5'h01, 4'h0);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wtry(1'b0);
		rd(4'h0);
		`CHK("function reset", 16'h00A0, v)
		key(5'h10, 4'h1);
		wtry(1'b1);
		key(5'h10, 4'h0);
		wtry(1'b0);
		key(5'h10, 4'h1);
		sw <= 1'b1;
		key(5'h10, 4'h0);
		wtry(1'b1);
		rd(4'h5);
		`CHK("lock bits", 2'h3, v[9:8])
		sw <= 1'b0;
		rd(4'hF);
		`CHK("unmapped", 16'h0000, v)
		key(5'h10, 4'h0);
		rd(4'h5);
		`CHK("lock bits", 2'h0, v[9:8])
		key(5'h04, 4'h0);
		wr(4'h0, 16'h00A1);
		key(5'h01, 4'h0);
		cc <= 10'h2E8;
		evt(8'h01, 8'h00);
		cc <= 10'h2E9;
		bsy <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rdy <= (i != 7);
			evt(8'h01 << i, 64'h2721222425111112 >> (56 - 8 * i));
		end
		bsy <= 1'b0;
		rdy <= 1'b1;
		key(5'h04, 4'h0);
		wr(4'h0, 16'h00C0);
		show(5'h01, 8'h0F, 8'h08);
		`CHK("offline", 1'b1, offline)
		show(5'h01, 8'h11, 8'h02);
		show(5'h01, 8'h12, 8'h01);
		key(5'h02, 4'h0);
		`CHK("clear prompt", 8'h0C, dc)
		key(5'h04, 4'h0);
		show(5'h01, 8'h0F, 8'h08);
		key(5'h02, 4'h0);
		show(5'h08, 8'h0F, 8'h00);
		key(5'h04, 4'h0);
		show(5'h01, 8'h00, 8'h00);
		t_seek(8'h31, 10'h005, 32'h05060705);
		t_seek(8'h41, 10'h005, 32'h07060507);
		t_seek(8'h51, 10'h005, 32'h05060507);
		t_seek(8'h61, 10'h005, 32'h07060705);
		t_seek(8'h71, 10'h005, 32'h00000000);
		t_seek(8'h81, 10'h005, 32'h05800580);
		t_seek(8'h81, 10'h000, 32'h80808080);
		wr(4'h0, 16'h00A1);
		bsy <= 1'b1;
		for (int i = 0; i < 260; i++)
			evt(8'h20, 8'h11);
		wr(4'h0, 16'h00C0);
		show(5'h01, 8'h0F, 8'hFF);
		show(5'h01, 8'h11, 8'hFF);
		complete_run;
	end
endmodule
